// ==== src/tts_defines.vh ====
`ifndef TTS_DEFINES_VH
`define TTS_DEFINES_VH

// Register byte addresses
`define TTS_ADDR_CTRL 8'h00
`define TTS_ADDR_OFFSET 8'h04
`define TTS_ADDR_SUBCODE 8'h08
`define TTS_ADDR_TAPETC 8'h0c
`define TTS_ADDR_STATUS 8'h10

// Control register fields
`define TTS_CTRL_TREF 0
`define TTS_CTRL_SRC_LSB 1
`define TTS_CTRL_SRC_MSB 3
`define TTS_CTRL_RATE_LSB 4
`define TTS_CTRL_RATE_MSB 6
`define TTS_CTRL_FOLLOW 7
`define TTS_CTRL_SYNCREQ 8
`define TTS_CTRL_HOUR_LSB 9
`define TTS_CTRL_HOUR_MSB 13
`define TTS_CTRL_RESET 14'h0000
`define TTS_CTRL_WRMASK 32'h00003fff

// Offset register fields: seconds of day and frames
`define TTS_OFS_SEC_MSB 16
`define TTS_OFS_FRM_LSB 17
`define TTS_OFS_FRM_MSB 22
`define TTS_OFS_RESET 23'h000000

// Tape timecode source selections
`define TTS_SRC_TRACK 3'h0
`define TTS_SRC_PLAIN 3'h1
`define TTS_SRC_OFFSET 3'h2
`define TTS_SRC_SHORT 3'h3
`define TTS_SRC_LONG 3'h4

// Frame rate selections
`define TTS_RATE_24 3'h0
`define TTS_RATE_25 3'h1
`define TTS_RATE_2997DF 3'h2
`define TTS_RATE_2997ND 3'h3
`define TTS_RATE_30DF 3'h4
`define TTS_RATE_30ND 3'h5

// Subcode frame pattern: 33, 33, 34 frames per second
`define TTS_SUB_MAXF_SHORT 6'h20
`define TTS_SUB_MAXF_LONG 6'h21
`define TTS_SUB_LONG_PHASE 2'h2

// Time constants
`define TTS_DAY_SEC 20'h15180
`define TTS_HOUR_SEC 17'h00e10
`define TTS_PREROLL_MIN 6'h39
`define TTS_SHORT_PERIOD_MIN 6'h0d
`define TTS_LONG_PERIOD_MIN 6'h17
`define TTS_DRIFT_SEC 11'h708

`endif

// ==== src/tts_subcode_counter.v ====
`timescale 1ns/10ps
`include "tts_defines.vh"

module tts_subcode_counter
(
   input wire pclk,
   input wire presetn,
   input wire frame_tick,
   input wire tape_reverse,
   input wire tape_start,
   output reg signed [17:0] sub_sec,
   output reg [5:0] sub_frame,
   output reg [1:0] sub_phase,
   output reg sec_up,
   output reg sec_dn
);

   wire [5:0] max_now;
   wire [1:0] phase_back;
   wire [5:0] max_back;

   // Frame limits of the current and previous second of the pattern
   assign max_now = (sub_phase == `TTS_SUB_LONG_PHASE) ?
      `TTS_SUB_MAXF_LONG : `TTS_SUB_MAXF_SHORT;
   assign phase_back = (sub_phase == 2'h0) ? 2'h2 : sub_phase - 2'h1;
   assign max_back = (phase_back == `TTS_SUB_LONG_PHASE) ?
      `TTS_SUB_MAXF_LONG : `TTS_SUB_MAXF_SHORT;

   // Count subcode frames up or down, zero at tape start
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sub_sec <= 18'sd0;
         sub_frame <= 6'h00;
         sub_phase <= 2'h0;
         sec_up <= 1'b0;
         sec_dn <= 1'b0;
      end
      else
      begin
         sec_up <= 1'b0;
         sec_dn <= 1'b0;
         if (tape_start)
         begin
            sub_sec <= 18'sd0;
            sub_frame <= 6'h00;
            sub_phase <= 2'h0;
         end
         else if (frame_tick && !tape_reverse)
         begin
            if (sub_frame == max_now)
            begin
               sub_frame <= 6'h00;
               sub_sec <= sub_sec + 18'sd1;
               sub_phase <= (sub_phase == 2'h2) ? 2'h0 : sub_phase + 2'h1;
               sec_up <= 1'b1;
            end
            else
               sub_frame <= sub_frame + 6'h01;
         end
         else if (frame_tick)
         begin
            if (sub_frame == 6'h00)
            begin
               sub_frame <= max_back;
               sub_sec <= sub_sec - 18'sd1;
               sub_phase <= phase_back;
               sec_dn <= 1'b1;
            end
            else
               sub_frame <= sub_frame - 6'h01;
         end
      end
   end

endmodule

// ==== src/tts_synth.v ====
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "tts_defines.vh"

// How it works
// - Subcode time reads zero at physical tape start and counts up.
// - Subcode seconds hold 33, 33, then 34 frames; 100 per three seconds.
// - Slave link always carries subcode time, never timecode.
// - With follow-master on, chase incoming timecode whatever reference.
// - External controller time is always the tape timecode value.
// - Exactly one indicator lit: subcode or timecode reference.
// - Reference select picks subcode or timecode; subcode blocks tc sync.
// - Five tape timecode sources: track, plain, offset, short, long.
// - Synthesized timecode leaves on the same outputs as track timecode.
// - Track source passes recorded track timecode unconverted.
// - Track source with no timecode on tape shows dashes.
// - Plain synthesis outputs subcode time as timecode, start is zero.
// - Negative subcode time wraps to just before midnight.
// - Synthesized frames use the selected system frame rate.
// - At 29.97 non-drop and 30 drop, seconds drift two per hour.
// - Offset synthesis adds the user offset; offset is tape-start time.
// - Pre-roll modes start tape at selected hour, 57 minutes, zero.
// - Pre-roll restarts next hour plus 57 every 13 or 23 minutes.
module tts_synth
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire frame_tick,
   input wire tape_reverse,
   input wire tape_start,
   input wire track_tc_present,
   input wire [16:0] track_tc_sec,
   input wire [5:0] track_tc_frame,
   input wire ext_tc_present,
   output reg [16:0] tape_timecode_source_sec,
   output reg [5:0] tape_timecode_source_frame,
   output reg tape_timecode_source_valid,
   output reg counter_dashes,
   output reg subcode_led,
   output reg timecode_led,
   output reg tc_sync_enable,
   output reg chase_active,
   output reg signed [17:0] link_sub_sec,
   output reg [5:0] link_sub_frame,
   output reg [16:0] ctrl_tc_sec,
   output reg [5:0] ctrl_tc_frame
);

   reg [13:0] ctrl;
   reg [22:0] offset;
   reg [10:0] drift_pos;
   reg signed [17:0] drift_sec;
   reg [16:0] next_sec;
   reg [5:0] next_frame;
   reg next_valid;
   reg signed [19:0] sum;
   reg [6:0] fsum;
   reg [5:0] fps;
   reg [31:0] rd_val;
   reg rd_err;
   wire signed [17:0] sub_sec;
   wire [5:0] sub_frame;
   wire [1:0] sub_phase;
   wire sec_up;
   wire sec_dn;
   wire [11:0] prod;
   wire [5:0] syn_frame;
   wire time_ref_tc;
   wire [2:0] tape_timecode_source;
   wire [2:0] rate;
   wire [4:0] preroll_hour;
   wire drift_on;
   wire [16:0] seg_sec [0:1];
   wire [19:0] day_sec = `TTS_DAY_SEC;

   assign time_ref_tc = ctrl[`TTS_CTRL_TREF];
   assign tape_timecode_source = ctrl[`TTS_CTRL_SRC_MSB:`TTS_CTRL_SRC_LSB];
   assign rate = ctrl[`TTS_CTRL_RATE_MSB:`TTS_CTRL_RATE_LSB];
   assign preroll_hour = ctrl[`TTS_CTRL_HOUR_MSB:`TTS_CTRL_HOUR_LSB];

   tts_subcode_counter u_count
   (
      .pclk(pclk),
      .presetn(presetn),
      .frame_tick(frame_tick),
      .tape_reverse(tape_reverse),
      .tape_start(tape_start),
      .sub_sec(sub_sec),
      .sub_frame(sub_frame),
      .sub_phase(sub_phase),
      .sec_up(sec_up),
      .sec_dn(sec_dn)
   );

   // Nominal frames per second of the selected system rate
   always @*
   begin
      case (rate)
         `TTS_RATE_24: fps = 6'd24;
         `TTS_RATE_25: fps = 6'd25;
         default: fps = 6'd30;
      endcase
   end

   // Map subcode frame into a frame at the system rate
   assign prod = ({6'h00, sub_frame} * {6'h00, fps}) /
      ((sub_phase == `TTS_SUB_LONG_PHASE) ? 12'd34 : 12'd33);
   assign syn_frame = prod[5:0];
   assign drift_on = (rate == `TTS_RATE_2997ND) || (rate == `TTS_RATE_30DF);

   // Drift accumulator: one second lost per 1800 subcode seconds
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drift_pos <= 11'h000;
         drift_sec <= 18'sd0;
      end
      else if (tape_start)
      begin
         drift_pos <= 11'h000;
         drift_sec <= 18'sd0;
      end
      else if (sec_up)
      begin
         if (drift_pos == `TTS_DRIFT_SEC - 11'h001)
         begin
            drift_pos <= 11'h000;
            drift_sec <= drift_sec + 18'sd1;
         end
         else
            drift_pos <= drift_pos + 11'h001;
      end
      else if (sec_dn)
      begin
         if (drift_pos == 11'h000)
         begin
            drift_pos <= `TTS_DRIFT_SEC - 11'h001;
            drift_sec <= drift_sec - 18'sd1;
         end
         else
            drift_pos <= drift_pos - 11'h001;
      end
   end

   // Pre-roll segment trackers, one per pre-roll length
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : seg
         localparam [10:0] PERIOD = 11'd60 * ((g == 0) ?
            {5'h00, `TTS_SHORT_PERIOD_MIN} : {5'h00, `TTS_LONG_PERIOD_MIN});
         reg [10:0] pos;
         reg [4:0] hr;
         wire [5:0] hsum;
         wire [4:0] hmod;
         wire [17:0] tot;
         assign hsum = {1'b0, preroll_hour} + {1'b0, hr};
         assign hmod = (hsum >= 6'd24) ? hsum[4:0] - 5'd24 : hsum[4:0];
         assign tot = {13'h0000, hmod} * {1'b0, `TTS_HOUR_SEC} +
            {12'h000, `TTS_PREROLL_MIN} * 18'd60 + {7'h00, pos};
         assign seg_sec[g] = (tot >= `TTS_DAY_SEC) ?
            tot[16:0] - day_sec[16:0] : tot[16:0];

         // Restart at the next hour plus 57 minutes each period
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pos <= 11'h000;
               hr <= 5'h00;
            end
            else if (tape_start)
            begin
               pos <= 11'h000;
               hr <= 5'h00;
            end
            else if (sec_up)
            begin
               if (pos == PERIOD - 11'h001)
               begin
                  pos <= 11'h000;
                  hr <= (hr == 5'd23) ? 5'h00 : hr + 5'h01;
               end
               else
                  pos <= pos + 11'h001;
            end
            else if (sec_dn)
            begin
               if (pos == 11'h000)
               begin
                  pos <= PERIOD - 11'h001;
                  hr <= (hr == 5'h00) ? 5'd23 : hr - 5'h01;
               end
               else
                  pos <= pos - 11'h001;
            end
         end
      end
   endgenerate

   // Select tape timecode source and form the next value
   always @*
   begin
      next_valid = 1'b1;
      next_sec = 17'h00000;
      next_frame = syn_frame;
      fsum = {1'b0, syn_frame};
      sum = {{2{sub_sec[17]}}, sub_sec};
      case (tape_timecode_source)
         `TTS_SRC_PLAIN, `TTS_SRC_OFFSET:
         begin
            if (drift_on)
               sum = sum - {{2{drift_sec[17]}}, drift_sec};
            if (tape_timecode_source == `TTS_SRC_OFFSET)
            begin
               fsum = {1'b0, syn_frame} +
                  {1'b0, offset[`TTS_OFS_FRM_MSB:`TTS_OFS_FRM_LSB]};
               sum = sum + {3'b000, offset[`TTS_OFS_SEC_MSB:0]};
               if (fsum >= {1'b0, fps})
               begin
                  fsum = fsum - {1'b0, fps};
                  sum = sum + 20'sd1;
               end
            end
            if (sum < 20'sd0)
               sum = sum + `TTS_DAY_SEC;
            if (sum >= $signed(day_sec))
               sum = sum - `TTS_DAY_SEC;
            next_sec = sum[16:0];
            next_frame = fsum[5:0];
         end
         `TTS_SRC_SHORT:
            next_sec = seg_sec[0];
         `TTS_SRC_LONG:
            next_sec = seg_sec[1];
         default:
         begin
            next_valid = track_tc_present;
            next_sec = track_tc_sec;
            next_frame = track_tc_frame;
         end
      endcase
   end

   // Time outputs, indicators and sync controls
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tape_timecode_source_sec <= 17'h00000;
         tape_timecode_source_frame <= 6'h00;
         tape_timecode_source_valid <= 1'b0;
         counter_dashes <= 1'b1;
         subcode_led <= 1'b1;
         timecode_led <= 1'b0;
         tc_sync_enable <= 1'b0;
         chase_active <= 1'b0;
         link_sub_sec <= 18'sd0;
         link_sub_frame <= 6'h00;
         ctrl_tc_sec <= 17'h00000;
         ctrl_tc_frame <= 6'h00;
      end
      else
      begin
         tape_timecode_source_sec <= next_sec;
         tape_timecode_source_frame <= next_frame;
         tape_timecode_source_valid <= next_valid;
         counter_dashes <= !next_valid;
         subcode_led <= !time_ref_tc;
         timecode_led <= time_ref_tc;
         tc_sync_enable <= time_ref_tc;
         chase_active <= ext_tc_present && (ctrl[`TTS_CTRL_FOLLOW] ||
            (time_ref_tc && ctrl[`TTS_CTRL_SYNCREQ]));
         link_sub_sec <= sub_sec;
         link_sub_frame <= sub_frame;
         ctrl_tc_sec <= next_sec;
         ctrl_tc_frame <= next_frame;
      end
   end

   // Read multiplexer, decoded in the setup phase
   always @*
   begin
      rd_err = 1'b0;
      rd_val = 32'h00000000;
      case (paddr)
         `TTS_ADDR_CTRL: rd_val = {18'h00000, ctrl};
         `TTS_ADDR_OFFSET: rd_val = {9'h000, offset};
         `TTS_ADDR_SUBCODE:
            rd_val = {6'h00, sub_phase, sub_frame, sub_sec};
         `TTS_ADDR_TAPETC:
            rd_val = {8'h00, tape_timecode_source_valid, tape_timecode_source_frame, tape_timecode_source_sec};
         `TTS_ADDR_STATUS:
            rd_val = {27'h0000000, chase_active, tc_sync_enable,
               counter_dashes, timecode_led, subcode_led};
         default: rd_err = 1'b1;
      endcase
   end

   // APB slave: zero wait states, writes land in the access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `TTS_CTRL_RESET;
         offset <= `TTS_OFS_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
         if (psel && !penable)
         begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= rd_err;
         end
         if (psel && penable && pwrite)
         begin
            if (paddr == `TTS_ADDR_CTRL)
               ctrl <= pwdata[13:0];
            else if (paddr == `TTS_ADDR_OFFSET)
               offset <= pwdata[22:0];
         end
      end
   end

endmodule

// ==== dv/tts_synth_checker.sv ====
`timescale 1ns/10ps
module tts_synth_checker
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire tape_start,
   input wire track_tc_present,
   input wire [16:0] track_tc_sec,
   input wire [5:0] track_tc_frame,
   input wire ext_tc_present,
   input wire [16:0] tape_timecode_source_sec,
   input wire [5:0] tape_timecode_source_frame,
   input wire tape_timecode_source_valid,
   input wire counter_dashes,
   input wire subcode_led,
   input wire timecode_led,
   input wire tc_sync_enable,
   input wire chase_active,
   input wire signed [17:0] link_sub_sec,
   input wire [5:0] link_sub_frame,
   input wire [16:0] ctrl_tc_sec,
   input wire [5:0] ctrl_tc_frame
);
   reg [13:0] ctrl;
   wire trk = ctrl[3:1] == 3'h0 || ctrl[3:1] > 3'h4;
   wire plain = ctrl[3:1] == 3'h1 && ctrl[6:4] == 3'h0;
   wire chase_exp = ext_tc_present && (ctrl[7] || (ctrl[0] && ctrl[8]));
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of the control word as software writes it
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         ctrl <= 14'h0000;
      else if (psel && penable && pready && pwrite && paddr == 8'h00)
         ctrl <= pwdata[13:0];
   led_onehot_a: assert property (subcode_led != timecode_led)
      else $error("reference indicators not exclusive");
   led_ref_a: assert property ($stable(ctrl[0]) [*3] |->
      timecode_led == ctrl[0]) else $error("indicator ignores reference");
   no_sync_a: assert property (subcode_led |-> !tc_sync_enable)
      else $error("timecode sync while on subcode");
   chase_a: assert property ($stable(chase_exp) [*3] |->
      chase_active == chase_exp) else $error("chase state wrong");
   frame_max_a: assert property (link_sub_frame <= 6'h21)
      else $error("subcode frame too large");
   sec_step_a: assert property (link_sub_sec != $past(link_sub_sec) |->
      link_sub_frame == 6'h00 || link_sub_frame >= 6'h20)
      else $error("second changed mid frame pattern");
   start_zero_a: assert property (tape_start |-> ##[1:2]
      (link_sub_sec == 18'sh0 && link_sub_frame == 6'h00))
      else $error("tape start not zero");
   ctrl_tc_a: assert property ((tape_timecode_source_valid && $stable(tape_timecode_source_sec) &&
      $stable(tape_timecode_source_frame)) [*2] |-> ctrl_tc_sec == tape_timecode_source_sec &&
      ctrl_tc_frame == tape_timecode_source_frame) else $error("controller time differs");
   dash_a: assert property ((trk && !track_tc_present) [*3] |->
      counter_dashes) else $error("no dashes without track");
   track_pass_a: assert property ((trk && track_tc_present &&
      $stable(track_tc_sec) && $stable(track_tc_frame)) [*3] |->
      tape_timecode_source_valid && tape_timecode_source_sec == track_tc_sec &&
      tape_timecode_source_frame == track_tc_frame) else $error("track time altered");
   plain_zero_a: assert property ((plain && link_sub_sec == 18'sh0 &&
      link_sub_frame == 6'h00) [*3] |-> tape_timecode_source_valid &&
      tape_timecode_source_sec == 17'h0 && tape_timecode_source_frame == 6'h00)
      else $error("tape start not zero timecode");
   neg_wrap_a: assert property ((plain && link_sub_sec == -18'sh1) [*3]
      |-> tape_timecode_source_sec == 17'h1517f) else $error("negative time not wrapped");
endmodule
bind tts_synth tts_synth_checker chk (.*);

// ==== dv/tts_tape_model.sv ====
`timescale 1ns/10ps
module tts_tape_model
(
   input wire pclk,
   output reg frame_tick,
   output reg tape_reverse,
   output reg tape_start,
   output reg track_tc_present,
   output reg [16:0] track_tc_sec,
   output reg [5:0] track_tc_frame,
   output reg ext_tc_present
);
   // Transport at rest, no timecode anywhere
   initial
   begin
      {frame_tick, tape_reverse, tape_start} = 3'h0;
      {track_tc_present, ext_tc_present} = 2'h0;
      track_tc_sec = 17'h0;
      track_tc_frame = 6'h00;
   end
   // Pulse at the physical start of the tape
   task start_tape;
      begin
         @(posedge pclk);
         tape_start <= 1'b1;
         @(posedge pclk);
         tape_start <= 1'b0;
      end
   endtask
   // Pass n frames; slow leaves a gap after every frame
   task move(input integer n, input rev, input slow);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            @(posedge pclk);
            tape_reverse <= rev;
            frame_tick <= 1'b1;
            if (slow)
            begin
               @(posedge pclk);
               frame_tick <= 1'b0;
            end
         end
         @(posedge pclk);
         frame_tick <= 1'b0;
      end
   endtask
   // Track reader; a lost track leaves garbage, not the old value
   task track(input p, input [16:0] s, input [5:0] f, input x);
      begin
         @(posedge pclk);
         track_tc_present <= p;
         track_tc_sec <= p ? s : ~track_tc_sec;
         track_tc_frame <= p ? f : ~track_tc_frame;
         ext_tc_present <= x;
      end
   endtask
endmodule

// ==== dv/tb_tape_timecode_synthesizer.sv ====
`timescale 1ns/10ps
`include "tts_defines.vh"
`define CHK(g, e) \
   begin \
      num_checks = num_checks + 1; \
      if ((g) !== (e)) \
      begin \
         mismatches = mismatches + 1; \
         $display("wrong value t=%0t got %h exp %h", $time, g, e); \
      end \
   end
module tb_tape_timecode_synthesizer;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, tick, rev, start, tpres, xpres;
   wire [16:0] tsec;
   wire [5:0] tfrm;
   integer mismatches = 0;
   integer num_checks = 0;
   integer seed = 15;
   integer i;
   reg [16:0] rs;
   reg [5:0] rf;
   reg [32:0] exp_word;
   reg [32:0] expq[$];
   tts_tape_model tape (.pclk(pclk), .frame_tick(tick), .tape_reverse(rev),
      .tape_start(start), .track_tc_present(tpres), .track_tc_sec(tsec),
      .track_tc_frame(tfrm), .ext_tc_present(xpres));
   tts_synth dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_tick(tick), .tape_reverse(rev), .tape_start(start),
      .track_tc_present(tpres), .track_tc_sec(tsec), .track_tc_frame(tfrm),
      .ext_tc_present(xpres), .tape_timecode_source_sec(), .tape_timecode_source_frame(),
      .tape_timecode_source_valid(), .counter_dashes(), .subcode_led(), .timecode_led(),
      .tc_sync_enable(), .chase_active(), .link_sub_sec(),
      .link_sub_frame(), .ctrl_tc_sec(), .ctrl_tc_frame());
   always #5 pclk = ~pclk;
   function [32:0] tcw(input [16:0] s, input [5:0] f);
      tcw = {9'h000, 1'b1, f, s};
   endfunction
   // APB master; reads note the expected {error, data} word
   task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         if (!w)
            expq.push_back(e);
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         if (w)
            repeat (2) @(posedge pclk);
      end
   endtask
   // Pre-roll source at hour h, t seconds into the tape
   task pre(input integer h, input integer lg, input integer t);
      integer p;
      begin
         p = (lg ? `TTS_LONG_PERIOD_MIN : `TTS_SHORT_PERIOD_MIN) * 60;
         apb(1, 8'h00, (h << 9) | ((3 + lg) << 1), 0);
         apb(0, 8'h0c, 0, tcw(((h + t / p) % 24) * `TTS_HOUR_SEC +
            `TTS_PREROLL_MIN * 60 + t % p, 6'h00));
      end
   endtask
   task st(input [31:0] c, input x, input [32:0] e);
      begin
         tape.track(1'b1, rs, rf, x);
         apb(1, 8'h00, c, 0);
         apb(0, 8'h10, 0, e);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Each completed read is compared with the oldest note
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
      begin
         exp_word = expq.pop_front();
         `CHK({pslverr, prdata}, exp_word)
      end
   initial
   begin
      #500000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h00, 0, 33'h0);
      apb(0, 8'h04, 0, 33'h0);
      apb(0, 8'h10, 0, 33'h5);
      apb(0, 8'h14, 0, {1'b1, 32'h0});
      // One frame back from the start falls in the long third second
      tape.start_tape;
      tape.move(1, 1'b1, 1'b0);
      apb(1, 8'h00, 32'h2, 0);
      apb(0, 8'h08, 0, {7'h00, 2'h2, 6'h21, 18'h3ffff});
      apb(0, 8'h0c, 0, tcw(`TTS_DAY_SEC - 1, 33 * 24 / 34));
      tape.move(1, 1'b0, 1'b0);
      apb(0, 8'h08, 0, 33'h0);
      apb(0, 8'h0c, 0, tcw(0, 0));
      tape.move(99, 1'b0, 1'b1);
      apb(0, 8'h08, 0, {7'h00, 2'h2, 6'h21, 18'h2});
      for (i = 0; i < 6; i = i + 1)
      begin
         apb(1, 8'h00, (i << 4) | 2, 0);
         rf = 33 * (i == 0 ? 24 : i == 1 ? 25 : 30) / 34;
         apb(0, 8'h0c, 0, tcw(2, rf));
      end
      tape.move(1, 1'b0, 1'b0);
      rs = `TTS_DAY_SEC - 2;
      apb(1, 8'h04, {9'h000, 6'h05, rs}, 0);
      apb(1, 8'h00, 32'h54, 0);
      apb(0, 8'h0c, 0, tcw(1, 5));
      // Restart periods leave room for 10 and 20 minute pieces
      pre(23, 0, 3);
      pre(5, 1, 3);
      tape.move(26000, 1'b0, 1'b0);
      pre(23, 0, 783);
      pre(5, 1, 783);
      tape.start_tape;
      apb(0, 8'h08, 0, 33'h0);
      apb(1, 8'h00, 0, 0);
      for (i = 0; i < 3; i = i + 1)
      begin
         rs = {$random(seed)} % 86400;
         rf = {$random(seed)} % 24;
         tape.track(1'b1, rs, rf, 1'b0);
         apb(0, 8'h0c, 0, tcw(rs, rf));
         tape.track(1'b0, 0, 0, 1'b0);
         apb(0, 8'h10, 0, 33'h5);
      end
      st(32'h000, 1'b1, 33'h01);
      st(32'h080, 1'b1, 33'h11);
      st(32'h001, 1'b1, 33'h0a);
      st(32'h101, 1'b1, 33'h1a);
      st(32'h081, 1'b0, 33'h0a);
      summarize;
   end
endmodule
